/* File: verilog/aics_pkg.sv */
// constants, types and the behaviour list for the analog input channel sequencer
// Behaviour
// [RQ1] only enabled channels are converted; disabled channels are skipped entirely; in the code one disabled after selection still takes a slot
// [RQ2] scan period is (configure time + conversion time) times enabled channel count
// [RQ3] each channel first selects the mux input, then programs the gain amplifier
// [RQ4] conversion phase is at least result read time plus processing time
// [RQ5] after reset every channel is disabled until software enables it
// [RQ6] corrected sample is (raw minus stored offset) times stored gain
// [RQ7] offset is captured at zero input before gain is stored at full scale
// [RQ8] separate offset and gain per channel and per range, factory values as default
// [RQ9] factory coefficients stay untouched; a restore reloads them over user values
// [RQ10] each channel picks none, block, time-window or moving averaging
// [RQ11] standard variant gives 14-bit results, high-resolution variant 18-bit results
// [RQ12] unconfigured averaging mode means no averaging, one output per scan
// [RQ13] channels are visited in ascending order, restarting at the lowest enabled one
// [RQ14] a stored coefficient applies from that channel's next conversion only; the code also applies it to a conversion still in progress
package aics_pkg;
  localparam int unsigned CH_N = 4;
  localparam int unsigned RNG_N = 3;
  localparam int unsigned ENT_N = CH_N * RNG_N;
  localparam int unsigned GAIN_FRAC = 14;
  localparam int unsigned MOV_DEPTH = 8;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CH_EN = 8'h04;
  localparam logic [7:0] REG_CAL_GAIN = 8'h08;
  localparam logic [7:0] REG_CAL_CMD = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [3:0] PAGE_CFG = 4'h2;
  localparam logic [3:0] PAGE_RESULT = 4'h3;
  localparam logic [3:0] PAGE_RAW = 4'h4;
  // field positions
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned CTRL_HIRES = 1;
  localparam int unsigned CMD_OFFSET = 4;
  localparam int unsigned CMD_GAIN = 5;
  localparam int unsigned CMD_RESTORE = 6;
  localparam int unsigned ST_CAL_ERR = 1;
  // reset values
  localparam logic [1:0] RANGE_RST = 2'h1;
  localparam logic [9:0] COUNT_RST = 10'h002;
  localparam logic signed [17:0] FACT_OFFSET = 18'sh00000;
  localparam logic [15:0] FACT_GAIN = 16'h4000;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned T_MUX_NS = 2000;
  localparam int unsigned T_PGA_NS = 1000;
  localparam int unsigned T_CONV_STD_NS = 10000;
  localparam int unsigned T_CONV_HI_NS = 40000;
  localparam int unsigned T_MS_NS = 1000000;
  localparam logic [11:0] MUX_CYC = 12'((T_MUX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] PGA_CYC = 12'((T_PGA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] CONV_STD_CYC =
    12'((T_CONV_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] CONV_HI_CYC = 12'((T_CONV_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned MS_CYC = T_MS_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    AVG_NONE = 2'b00,
    AVG_BLOCK = 2'b01,
    AVG_TIME = 2'b10,
    AVG_MOVING = 2'b11
  } aics_avg_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_MUX = 3'b001,
    S_PGA = 3'b010,
    S_START = 3'b011,
    S_WAIT = 3'b100,
    S_READ = 3'b101,
    S_CALC = 3'b110,
    S_PAD = 3'b111
  } aics_state_t;
endpackage

/* File: verilog/aics_coef_if.sv */
// coefficient memory port between the sequencer and its calibration store
`timescale 1ns/1ps
interface aics_coef_if;
  logic [3:0] rd_idx;
  logic signed [17:0] rd_off;
  logic [15:0] rd_gain;
  logic wr_en;
  logic wr_fact;
  logic wr_off_en;
  logic wr_gain_en;
  logic [3:0] wr_idx;
  logic signed [17:0] wr_off;
  logic [15:0] wr_gain;
  modport ctl (output rd_idx, wr_en, wr_fact, wr_off_en, wr_gain_en, wr_idx, wr_off, wr_gain,
    input rd_off, rd_gain);
  modport mem (input rd_idx, wr_en, wr_fact, wr_off_en, wr_gain_en, wr_idx, wr_off, wr_gain,
    output rd_off, rd_gain);
endinterface

/* File: verilog/aics_coef_mem.sv */
// per channel and range offset/gain store with factory defaults
`timescale 1ns/1ps
module aics_coef_mem (
  input wire logic clk,
  input wire logic rst,
  aics_coef_if.mem cif
);
  logic signed [17:0] off_q [aics_pkg::ENT_N];
  logic [15:0] gain_q [aics_pkg::ENT_N];

  // factory values are constants, so a restore can always bring them back
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < aics_pkg::ENT_N; i++) begin
        off_q[i] <= aics_pkg::FACT_OFFSET; // see [RQ8]
        gain_q[i] <= aics_pkg::FACT_GAIN;
      end
    end else if (cif.wr_en) begin
      if (cif.wr_fact) begin
        off_q[cif.wr_idx] <= aics_pkg::FACT_OFFSET; // see [RQ9]
        gain_q[cif.wr_idx] <= aics_pkg::FACT_GAIN;
      end else begin
        if (cif.wr_off_en) begin
          off_q[cif.wr_idx] <= cif.wr_off;
        end
        if (cif.wr_gain_en) begin
          gain_q[cif.wr_idx] <= cif.wr_gain;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    cif.rd_off <= off_q[cif.rd_idx];
    cif.rd_gain <= gain_q[cif.rd_idx];
  end

  chk_restore_factory: assert property (@(posedge clk) disable iff (rst) // see [RQ9]
    cif.wr_en && cif.wr_fact |=> off_q[$past(cif.wr_idx)] == aics_pkg::FACT_OFFSET
      && gain_q[$past(cif.wr_idx)] == aics_pkg::FACT_GAIN)
    else $error("restore did not reload factory coefficients");
endmodule

/* File: verilog/aics_avg.sv */
// averaging stage for one channel: none, block, time window or moving
`timescale 1ns/1ps
module aics_avg (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_vld,
  input wire logic signed [31:0] in_val,
  input wire aics_pkg::aics_avg_t mode,
  input wire logic [9:0] count,
  input wire logic ms_tick,
  output logic out_vld,
  output logic signed [31:0] out_val
);
  logic signed [41:0] acc_q;
  logic [9:0] n_q;
  logic [9:0] t_q;
  logic signed [31:0] hist_q [aics_pkg::MOV_DEPTH];
  logic [3:0] fill_q;
  logic pend_q;
  logic [9:0] blk_n;
  logic [3:0] mov_n;
  logic signed [41:0] mov_sum;
  logic signed [41:0] acc_in;

  always_comb begin
    blk_n = (count < 10'h002) ? 10'h002 : count;
    if (count > 10'(aics_pkg::MOV_DEPTH)) begin
      mov_n = 4'(aics_pkg::MOV_DEPTH);
    end else if (count < 10'h002) begin
      mov_n = 4'h2;
    end else begin
      mov_n = count[3:0];
    end
    acc_in = in_vld ? acc_q + 42'(in_val) : acc_q;
    mov_sum = '0;
    for (int i = 0; i < aics_pkg::MOV_DEPTH; i++) begin
      if (4'(i) < mov_n) begin
        mov_sum = mov_sum + 42'(hist_q[i]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fill_q <= 4'h0;
      pend_q <= 1'b0;
      for (int i = 0; i < aics_pkg::MOV_DEPTH; i++) begin
        hist_q[i] <= 32'sh0;
      end
    end else begin
      pend_q <= in_vld;
      if (in_vld) begin
        hist_q[0] <= in_val;
        for (int i = 1; i < aics_pkg::MOV_DEPTH; i++) begin
          hist_q[i] <= hist_q[i - 1];
        end
        if (fill_q < 4'(aics_pkg::MOV_DEPTH)) begin
          fill_q <= fill_q + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_q <= '0;
      n_q <= 10'h000;
      t_q <= 10'h000;
      out_vld <= 1'b0;
      out_val <= 32'sh0;
    end else begin
      out_vld <= 1'b0;
      case (mode) // see [RQ10]
        aics_pkg::AVG_NONE: begin
          if (in_vld) begin
            out_vld <= 1'b1; // see [RQ12]
            out_val <= in_val;
          end
        end
        aics_pkg::AVG_BLOCK: begin
          if (in_vld && 10'(n_q + 10'h001) >= blk_n) begin
            out_vld <= 1'b1;
            out_val <= 32'(acc_in / $signed({32'h0, blk_n}));
            acc_q <= '0;
            n_q <= 10'h000;
          end else if (in_vld) begin
            acc_q <= acc_in;
            n_q <= 10'(n_q + 10'h001);
          end
        end
        aics_pkg::AVG_TIME: begin
          if (ms_tick && 10'(t_q + 10'h001) >= count) begin
            if (n_q != 10'h000 || in_vld) begin
              out_vld <= 1'b1;
              out_val <= 32'(acc_in / $signed({32'h0, 10'(n_q + 10'(in_vld))}));
            end
            acc_q <= '0;
            n_q <= 10'h000;
            t_q <= 10'h000;
          end else begin
            acc_q <= acc_in;
            n_q <= 10'(n_q + 10'(in_vld));
            t_q <= 10'(t_q + 10'(ms_tick));
          end
        end
        default: begin
          if (pend_q && fill_q >= mov_n) begin
            out_vld <= 1'b1;
            out_val <= 32'(mov_sum / $signed({38'h0, mov_n}));
          end
        end
      endcase
    end
  end

  chk_none_pass: assert property (@(posedge clk) disable iff (rst) // see [RQ12]
    mode == aics_pkg::AVG_NONE && in_vld |=> out_vld && out_val == $past(in_val))
    else $error("no-average mode did not pass the sample through");
endmodule

/* File: verilog/aics_top.sv */
// channel sequencer top: apb registers, scan control and calibration correction
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module aics_top #(
  parameter int unsigned MS_CYCLES = aics_pkg::MS_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [1:0] MUX_SEL,
  output logic [2:0] PGA_GAIN,
  output logic ADC_START,
  input wire logic ADC_DONE,
  input wire logic [17:0] ADC_DATA
);
  aics_pkg::aics_state_t state_q;
  logic run_q;
  logic hires_q;
  logic [3:0] en_q;
  logic [15:0] cal_gain_q;
  logic cal_err_q;
  logic [1:0] range_q [aics_pkg::CH_N];
  aics_pkg::aics_avg_t mode_q [aics_pkg::CH_N];
  logic [2:0] pga_q [aics_pkg::CH_N];
  logic [9:0] count_q [aics_pkg::CH_N];
  logic signed [31:0] res_q [aics_pkg::CH_N];
  logic signed [17:0] raw_last_q [aics_pkg::CH_N];
  logic [15:0] scan_cnt_q;
  logic [1:0] ch_q;
  logic [11:0] cfg_cnt_q;
  logic [11:0] conv_cnt_q;
  logic signed [17:0] raw_q;
  logic signed [31:0] corr_q;
  logic corr_vld_q;
  logic done_s1_q;
  logic done_s2_q;
  logic done_s3_q;
  logic [17:0] data_s1_q;
  logic [17:0] data_s2_q;
  logic [16:0] ms_cnt_q;
  logic ms_tick_q;
  logic rest_q;
  logic [3:0] rest_idx_q;
  logic [aics_pkg::ENT_N-1:0] off_done_q;
  logic [1:0] last_ch_q;

  logic apb_setup;
  logic apb_wr;
  logic mapped;
  logic [2:0] nxt;
  logic [2:0] first;
  logic done_rise;
  logic [11:0] conv_len;
  logic cmd_wr;
  logic [1:0] cmd_ch;
  logic [3:0] cmd_idx;
  logic cmd_off;
  logic cmd_gain;
  logic cmd_bad;
  logic [31:0] rd_mux;
  logic signed [18:0] diff;
  logic signed [35:0] prod;
  logic [aics_pkg::CH_N-1:0] avg_vld;
  logic signed [31:0] avg_val [aics_pkg::CH_N];

  aics_coef_if cif ();

  // lowest enabled channel at or above lo; 4 when none
  function automatic logic [2:0] find_en(input logic [3:0] en, input logic [2:0] lo);
    logic [2:0] r;
    r = 3'h4;
    for (int i = 3; i >= 0; i--) begin
      if (en[i] && 3'(i) >= lo) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // range code 3 is unused and falls back to the default range
  function automatic logic [3:0] ent_idx(input logic [1:0] ch, input logic [1:0] rng);
    logic [1:0] r;
    r = (rng == 2'h3) ? aics_pkg::RANGE_RST : rng;
    return 4'({2'h0, ch} * 4'h3 + {2'h0, r});
  endfunction

  always_comb begin
    apb_setup = PSEL && !PENABLE;
    apb_wr = PSEL && PENABLE && PWRITE;
    PREADY = 1'b1;
    PSLVERR = PSEL && PENABLE && !mapped;
    nxt = find_en(en_q, 3'({1'b0, ch_q} + 3'h1)); // see [RQ13]
    first = find_en(en_q, 3'h0);
    done_rise = done_s2_q && !done_s3_q;
    conv_len = hires_q ? aics_pkg::CONV_HI_CYC : aics_pkg::CONV_STD_CYC;
    cmd_wr = apb_wr && PADDR == aics_pkg::REG_CAL_CMD;
    cmd_ch = PWDATA[1:0];
    cmd_idx = ent_idx(cmd_ch, PWDATA[3:2]);
    cmd_off = cmd_wr && PWDATA[aics_pkg::CMD_OFFSET];
    cmd_gain = cmd_wr && PWDATA[aics_pkg::CMD_GAIN];
    // a gain store needs a fresh offset capture for that entry first
    cmd_bad = (cmd_off || cmd_gain) && rest_q || cmd_gain && !off_done_q[cmd_idx];
    diff = 19'(raw_q) - 19'(cif.rd_off);
    prod = 36'(diff) * $signed({20'h0, cif.rd_gain});
  end

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (PADDR[7:4])
      4'h0, 4'h1: begin
        case (PADDR)
          aics_pkg::REG_CTRL: rd_mux = {30'h0, hires_q, run_q};
          aics_pkg::REG_CH_EN: rd_mux = {28'h0, en_q};
          aics_pkg::REG_CAL_GAIN: rd_mux = {16'h0, cal_gain_q};
          aics_pkg::REG_CAL_CMD: rd_mux = 32'h0000_0000;
          aics_pkg::REG_STATUS: rd_mux = {scan_cnt_q, 10'h0, ch_q, 1'b0, rest_q, cal_err_q,
            state_q != aics_pkg::S_IDLE};
          default: mapped = 1'b0;
        endcase
      end
      aics_pkg::PAGE_CFG: rd_mux = {6'h0, count_q[PADDR[3:2]], 9'h0, pga_q[PADDR[3:2]],
        mode_q[PADDR[3:2]], range_q[PADDR[3:2]]};
      aics_pkg::PAGE_RESULT: rd_mux = res_q[PADDR[3:2]];
      aics_pkg::PAGE_RAW: rd_mux = 32'(raw_last_q[PADDR[3:2]]);
      default: mapped = 1'b0;
    endcase
    if (PADDR[1:0] != 2'h0) begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (apb_setup) begin
      PRDATA <= rd_mux;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      run_q <= 1'b0;
      hires_q <= 1'b0;
      en_q <= 4'h0; // see [RQ5]
      cal_gain_q <= aics_pkg::FACT_GAIN;
      for (int i = 0; i < aics_pkg::CH_N; i++) begin
        range_q[i] <= aics_pkg::RANGE_RST;
        mode_q[i] <= aics_pkg::AVG_NONE; // see [RQ12]
        pga_q[i] <= 3'h0;
        count_q[i] <= aics_pkg::COUNT_RST;
      end
    end else if (apb_wr && mapped) begin
      if (PADDR == aics_pkg::REG_CTRL) begin
        run_q <= PWDATA[aics_pkg::CTRL_RUN];
        hires_q <= PWDATA[aics_pkg::CTRL_HIRES];
      end
      if (PADDR == aics_pkg::REG_CH_EN) begin
        en_q <= PWDATA[3:0];
      end
      if (PADDR == aics_pkg::REG_CAL_GAIN) begin
        cal_gain_q <= PWDATA[15:0];
      end
      if (PADDR[7:4] == aics_pkg::PAGE_CFG) begin
        range_q[PADDR[3:2]] <= PWDATA[1:0];
        mode_q[PADDR[3:2]] <= aics_pkg::aics_avg_t'(PWDATA[3:2]);
        pga_q[PADDR[3:2]] <= PWDATA[6:4];
        count_q[PADDR[3:2]] <= PWDATA[25:16];
      end
    end
  end

  // calibration: offset capture, gain store, factory restore walk
  always_ff @(posedge CLK) begin
    if (RST) begin
      cal_err_q <= 1'b0;
      rest_q <= 1'b0;
      rest_idx_q <= 4'h0;
      off_done_q <= '0;
    end else begin
      if (cmd_bad) begin
        cal_err_q <= 1'b1; // see [RQ7]
      end else if (apb_wr && PADDR == aics_pkg::REG_STATUS && PWDATA[aics_pkg::ST_CAL_ERR]) begin
        cal_err_q <= 1'b0;
      end
      if (!cmd_bad && cmd_off) begin
        off_done_q[cmd_idx] <= 1'b1; // see [RQ7]
      end else if (!cmd_bad && cmd_gain) begin
        off_done_q[cmd_idx] <= 1'b0;
      end
      if (rest_q) begin
        rest_idx_q <= 4'(rest_idx_q + 4'h1);
        if (rest_idx_q == 4'(aics_pkg::ENT_N - 1)) begin
          rest_q <= 1'b0;
          off_done_q <= '0;
        end
      end else if (cmd_wr && PWDATA[aics_pkg::CMD_RESTORE]) begin
        rest_q <= 1'b1; // see [RQ9]
        rest_idx_q <= 4'h0;
      end
    end
  end

  always_comb begin
    cif.rd_idx = ent_idx(ch_q, range_q[ch_q]); // see [RQ8]
    cif.wr_en = rest_q || (!cmd_bad && (cmd_off || cmd_gain)); // see [RQ14]
    cif.wr_fact = rest_q;
    cif.wr_off_en = cmd_off;
    cif.wr_gain_en = cmd_gain && !cmd_off;
    cif.wr_idx = rest_q ? rest_idx_q : cmd_idx;
    cif.wr_off = raw_last_q[cmd_ch];
    cif.wr_gain = cal_gain_q;
  end

  aics_coef_mem u_mem (
    .clk(CLK),
    .rst(RST),
    .cif(cif)
  );

  // converter done and data come from outside the clock domain
  always_ff @(posedge CLK) begin
    if (RST) begin
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_s3_q <= 1'b0;
      data_s1_q <= 18'h00000;
      data_s2_q <= 18'h00000;
    end else begin
      done_s1_q <= ADC_DONE;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
      data_s1_q <= ADC_DATA;
      data_s2_q <= data_s1_q;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ms_cnt_q <= 17'h00000;
      ms_tick_q <= 1'b0;
    end else begin
      ms_tick_q <= ms_cnt_q == 17'(MS_CYCLES - 1);
      ms_cnt_q <= (ms_cnt_q == 17'(MS_CYCLES - 1)) ? 17'h00000 : 17'(ms_cnt_q + 17'h00001);
    end
  end

  // scan: mux, gain, start, wait, read coefficients, correct, pad to phase length
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_q <= aics_pkg::S_IDLE;
      ch_q <= 2'h0;
      cfg_cnt_q <= 12'h000;
      conv_cnt_q <= 12'h000;
      scan_cnt_q <= 16'h0000;
      MUX_SEL <= 2'h0;
      PGA_GAIN <= 3'h0;
      ADC_START <= 1'b0;
      raw_q <= 18'sh00000;
      corr_q <= 32'sh0;
      corr_vld_q <= 1'b0;
      last_ch_q <= 2'h0;
      for (int i = 0; i < aics_pkg::CH_N; i++) begin
        raw_last_q[i] <= 18'sh00000;
      end
    end else begin
      ADC_START <= 1'b0;
      corr_vld_q <= 1'b0;
      cfg_cnt_q <= 12'(cfg_cnt_q + 12'h001);
      conv_cnt_q <= 12'(conv_cnt_q + 12'h001);
      case (state_q)
        aics_pkg::S_IDLE: begin
          if (run_q && !first[2]) begin
            ch_q <= first[1:0]; // see [RQ1]
            state_q <= aics_pkg::S_MUX;
            cfg_cnt_q <= 12'h000;
            MUX_SEL <= first[1:0];
          end
        end
        aics_pkg::S_MUX: begin
          if (cfg_cnt_q == 12'(aics_pkg::MUX_CYC - 12'h001)) begin
            PGA_GAIN <= pga_q[ch_q]; // see [RQ3]
            cfg_cnt_q <= 12'h000;
            state_q <= aics_pkg::S_PGA;
          end
        end
        aics_pkg::S_PGA: begin
          if (cfg_cnt_q == 12'(aics_pkg::PGA_CYC - 12'h001)) begin
            state_q <= aics_pkg::S_START;
          end
        end
        aics_pkg::S_START: begin
          conv_cnt_q <= 12'h000;
          if (en_q[ch_q]) begin
            ADC_START <= 1'b1; // see [RQ1]
            last_ch_q <= ch_q;
            state_q <= aics_pkg::S_WAIT;
          end else begin
            state_q <= aics_pkg::S_PAD;
          end
        end
        aics_pkg::S_WAIT: begin
          if (done_rise) begin
            // standard variant keeps 14 bits, sign extended
            raw_q <= hires_q ? data_s2_q : {{4{data_s2_q[13]}}, data_s2_q[13:0]}; // see [RQ11]
            state_q <= aics_pkg::S_READ;
          end
        end
        aics_pkg::S_READ: begin
          raw_last_q[ch_q] <= raw_q;
          state_q <= aics_pkg::S_CALC;
        end
        aics_pkg::S_CALC: begin
          corr_q <= 32'(prod >>> aics_pkg::GAIN_FRAC); // see [RQ6]
          corr_vld_q <= 1'b1;
          state_q <= aics_pkg::S_PAD;
        end
        default: begin
          if (conv_cnt_q >= 12'(conv_len - 12'h001)) begin // see [RQ4]
            cfg_cnt_q <= 12'h000;
            if (!run_q || first[2]) begin
              state_q <= aics_pkg::S_IDLE;
            end else if (!nxt[2]) begin
              ch_q <= nxt[1:0]; // see [RQ13]
              MUX_SEL <= nxt[1:0];
              state_q <= aics_pkg::S_MUX;
            end else begin
              ch_q <= first[1:0]; // see [RQ2]
              MUX_SEL <= first[1:0];
              scan_cnt_q <= 16'(scan_cnt_q + 16'h0001);
              state_q <= aics_pkg::S_MUX;
            end
          end
        end
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < aics_pkg::CH_N; g++) begin : g_avg
      aics_avg u_avg (
        .clk(CLK),
        .rst(RST),
        .in_vld(corr_vld_q && ch_q == 2'(g)),
        .in_val(corr_q),
        .mode(mode_q[g]),
        .count(count_q[g]),
        .ms_tick(ms_tick_q),
        .out_vld(avg_vld[g]),
        .out_val(avg_val[g])
      );
      always_ff @(posedge CLK) begin
        if (RST) begin
          res_q[g] <= 32'sh0;
        end else if (avg_vld[g]) begin
          res_q[g] <= avg_val[g];
        end
      end
    end
  endgenerate

  chk_skip_disabled: assert property (@(posedge CLK) disable iff (RST) // see [RQ1]
    ADC_START |-> $past(en_q[ch_q]))
    else $error("conversion started on a disabled channel");
  chk_scan_order: assert property (@(posedge CLK) disable iff (RST) // see [RQ13]
    $rose(state_q == aics_pkg::S_MUX) && $past(state_q) == aics_pkg::S_PAD
      |-> ch_q > $past(ch_q) || ch_q == $past(first[1:0]))
    else $error("channel visited out of ascending order");
  chk_cfg_order: assert property (@(posedge CLK) disable iff (RST) // see [RQ3]
    state_q == aics_pkg::S_PGA && $past(state_q) != aics_pkg::S_PGA
      |-> $past(state_q) == aics_pkg::S_MUX && $past(cfg_cnt_q) == aics_pkg::MUX_CYC - 12'h001)
    else $error("gain programmed before mux settle time elapsed");
  chk_conv_len: assert property (@(posedge CLK) disable iff (RST) // see [RQ4]
    state_q == aics_pkg::S_PAD ##1 state_q != aics_pkg::S_PAD
      |-> $past(conv_cnt_q) >= conv_len - 12'h001)
    else $error("conversion phase shorter than required");
  chk_reset_disabled: assert property (@(posedge CLK) // see [RQ5]
    RST |=> en_q == 4'h0 && state_q == aics_pkg::S_IDLE)
    else $error("channels not disabled after reset");
  chk_correct_math: assert property (@(posedge CLK) disable iff (RST) // see [RQ6]
    state_q == aics_pkg::S_CALC |=> corr_vld_q && corr_q == 32'($past(prod) >>> 14))
    else $error("corrected sample does not match offset and gain");
  chk_gain_order: assert property (@(posedge CLK) disable iff (RST) // see [RQ7]
    cmd_gain && !off_done_q[cmd_idx] |=> cal_err_q ##1 !$past(cif.wr_gain_en))
    else $error("gain stored without prior offset capture");
  chk_std_width: assert property (@(posedge CLK) disable iff (RST) // see [RQ11]
    state_q == aics_pkg::S_READ && !hires_q |-> raw_q[17:13] == {5{raw_q[13]}})
    else $error("standard variant result wider than 14 bits");
endmodule

/* File: testbench/aics_adc_model.sv */
// converter model: answers each start after a chosen latency
`timescale 1ns/1ps
module aics_adc_model (
  input wire logic clk,
  input wire logic start,
  input wire logic [7:0] lat,
  input wire logic [17:0] val,
  output logic done,
  output logic [17:0] data
);
  int n = 0;
  logic [17:0] v = 18'h00000;
  initial done = 1'b0;
  always @(posedge clk) begin
    if (start) v <= val;
    n <= start ? 1 : (n > 0 && n < lat + 12) ? n + 1 : 0;
    done <= n > lat && n <= lat + 4;
    // data is held well past the done edge, then driven to its inverse
    data <= (n >= lat && n < lat + 10) ? v : ~v;
  end
endmodule

/* File: testbench/aics_bench.sv */
// self-checking bench for the channel sequencer
`timescale 1ns/1ps
module aics_bench;
  localparam int SLOT = aics_pkg::MUX_CYC + aics_pkg::PGA_CYC + aics_pkg::CONV_STD_CYC + 1;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, pready, perr, e, adone, astart;
  logic [7:0] paddr = 8'h00, lat = 8'h05;
  logic [31:0] pwd = 32'h0, prd, r;
  logic [17:0] val = 18'h00100, adata;
  logic [1:0] mux;
  logic [2:0] pga;
  logic [2:0] pq[$];
  int err_total = 0, check_count = 0, starts = 0, cyc = 0;
  int tq[$];
  logic [1:0] cq[$];
  aics_top #(.MS_CYCLES(50)) dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwd), .PRDATA(prd), .PREADY(pready),
    .PSLVERR(perr), .MUX_SEL(mux), .PGA_GAIN(pga), .ADC_START(astart), .ADC_DONE(adone),
    .ADC_DATA(adata));
  aics_adc_model adc (.clk(clk), .start(astart), .lat(lat), .val(val), .done(adone),
    .data(adata));
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (astart === 1'b1) begin
      starts++;
      tq.push_back(cyc);
      cq.push_back(mux);
      pq.push_back(pga);
    end
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, pen, pwr, paddr, pwd} <= {2'b10, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prd;
    e = perr;
    {psel, pen} <= 2'b00;
    if (n >= 50) begin
      err_total++;
      end_sim;
    end
  endtask
  task automatic wait_starts(input int k);
    int t, n;
    t = starts + k;
    n = 0;
    while (starts < t && n < 20000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20000) begin
      err_total++;
      end_sim;
    end
  endtask
  task automatic t_reset;
    apb(1'b0, 8'h04, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk(r, 32'h00020001);
    apb(1'b0, 8'hfc, 32'h0);
    chk(32'(e), 32'h1);
    apb(1'b1, 8'h00, 32'h1);
    repeat (2000) @(posedge clk);
    chk(32'(starts), 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_scan;
    // channel 1 gets gain code 5 so the amplifier output can be watched
    apb(1'b1, 8'h24, 32'h00020051);
    apb(1'b1, 8'h04, 32'h0000000a);
    wait_starts(3);
    chk(32'(cq[0]), 32'h1);
    chk(32'(cq[1]), 32'h3);
    chk(32'(cq[2]), 32'h1);
    chk(32'(pq[0]), 32'h5);
    chk(32'(pq[1]), 32'h0);
    chk(32'(tq[1] - tq[0]), 32'(SLOT));
    chk(32'(tq[2] - tq[1]), 32'(SLOT));
    $display("t_scan done");
  endtask
  task automatic t_cal;
    apb(1'b1, 8'h0c, 32'h2f);
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(r[1]), 32'h1);
    apb(1'b1, 8'h10, 32'h2);
    apb(1'b0, 8'h34, 32'h0);
    chk(r, 32'h100);
    apb(1'b0, 8'h44, 32'h0);
    chk(r, 32'h100);
    apb(1'b1, 8'h0c, 32'h15);
    apb(1'b1, 8'h08, 32'h8000);
    apb(1'b1, 8'h0c, 32'h25);
    val <= 18'h00120;
    lat <= 8'd60;
    wait_starts(4);
    apb(1'b0, 8'h34, 32'h0);
    chk(r, 32'h40);
    apb(1'b0, 8'h3c, 32'h0);
    chk(r, 32'h120);
    apb(1'b1, 8'h0c, 32'h40);
    wait_starts(4);
    apb(1'b0, 8'h34, 32'h0);
    chk(r, 32'h120);
    // block average of two equal samples must keep the same value
    apb(1'b1, 8'h2c, 32'h00020005);
    apb(1'b0, 8'h2c, 32'h0);
    chk(r, 32'h00020005);
    wait_starts(5);
    apb(1'b0, 8'h3c, 32'h0);
    chk(r, 32'h120);
    $display("t_cal done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_scan;
    t_cal;
    end_sim;
  end
endmodule
